// file: dscm_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "dscm_map.vh"
module dscm_regs
(
    input  wire        CLK_SYS,
    input  wire        RST_B,
    input  wire [15:0] REG_ADDR,
    input  wire [15:0] REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    output reg  [15:0] REG_RDATA,
    output reg         REG_RVALID,
    input  wire        RUNNING,
    input  wire        REVERSE,
    input  wire        READY,
    input  wire        FAULT,
    input  wire        PARAMETER_SETTING_ERROR,
    input  wire        RELAY_OUTPUT,
    input  wire        PHOTO_OUTPUT_ONE,
    input  wire        PHOTO_OUTPUT_TWO,
    input  wire        SAFETY_INPUT_ONE,
    input  wire        SAFETY_INPUT_TWO,
    input  wire        LINK_SPEED_REFERENCE_ACTIVE,
    input  wire        LINK_RUN_CONTROL_ACTIVE,
    input  wire        OVERCURRENT_FAULT,
    input  wire        EARTH_LEAK_FAULT,
    input  wire        OVERVOLTAGE_FAULT,
    input  wire        LINK_COMM_ERROR,
    input  wire        BCAST_DIGITAL_INPUT_FIVE,
    input  wire        BCAST_DIGITAL_INPUT_SIX,
    input  wire        BCAST_DIGITAL_INPUT_SEVEN,
    output reg         DIGITAL_INPUT_FIVE,
    output reg         DIGITAL_INPUT_SIX,
    output reg         DIGITAL_INPUT_SEVEN,
    output reg  [2:0]  EXT_INPUT_CMD,
    output reg  [15:0] CAL_TIME,
    output reg  [15:0] CAL_YEARWD,
    output reg  [15:0] CAL_DATE,
    output reg         CAL_APPLIED
);
    // ==========================================
    // Writable registers
    reg  [15:0] cmdsel_r;
    reg  [15:0] extin_r;
    reg  [15:0] time_r;
    reg  [15:0] yearwd_r;
    reg  [15:0] date_r;
    reg  [15:0] apply_r;
    wire        cal_ok;

    // Decode of a register address match, used for every write target
    function hit;
        input [15:0] a;
        input [15:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    // ==========================================
    // Calendar range check
    dscm_cal_check u_chk
    (
        .time_val   (time_r),
        .yearwd_val (yearwd_r),
        .date_val   (date_r),
        .cal_ok     (cal_ok)
    );

    // ==========================================
    // Monitor words built from live drive state
    wire        mismatch = SAFETY_INPUT_ONE ^ SAFETY_INPUT_TWO;
    wire        removed  = ~SAFETY_INPUT_ONE & ~SAFETY_INPUT_TWO;
    wire [15:0] status_w = {LINK_RUN_CONTROL_ACTIVE,
                            LINK_SPEED_REFERENCE_ACTIVE,
                            removed, mismatch,
                            4'h0,
                            PHOTO_OUTPUT_TWO, PHOTO_OUTPUT_ONE,
                            RELAY_OUTPUT,
                            PARAMETER_SETTING_ERROR, FAULT, READY,
                            REVERSE, RUNNING};
    wire [15:0] fault1_w = {1'b0, LINK_COMM_ERROR, 12'h000,
                            OVERVOLTAGE_FAULT,
                            OVERCURRENT_FAULT | EARTH_LEAK_FAULT};

    // ==========================================
    // Register writes; monitor area has no write path
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            cmdsel_r <= 16'h0000;
            extin_r  <= 16'h0000;
            time_r   <= `DSCM_TIME_RST;
            yearwd_r <= `DSCM_YEARWD_RST;
            date_r   <= `DSCM_DATE_RST;
            apply_r  <= `DSCM_APPLY_RST;
        end
        else if (REG_WR)
        begin
            if (hit(REG_ADDR, `DSCM_ADR_CMDSEL))
                cmdsel_r <= REG_WDATA & `DSCM_CMDSEL_MASK;
            if (hit(REG_ADDR, `DSCM_ADR_EXTIN))
                extin_r <= REG_WDATA & `DSCM_EXTIN_MASK;
            if (hit(REG_ADDR, `DSCM_ADR_TIME))
                time_r <= REG_WDATA;
            if (hit(REG_ADDR, `DSCM_ADR_YEARWD))
                yearwd_r <= REG_WDATA;
            if (hit(REG_ADDR, `DSCM_ADR_DATE))
                date_r <= REG_WDATA;
            if (hit(REG_ADDR, `DSCM_ADR_APPLY) && REG_WDATA == `DSCM_APPLY_CMD)
                apply_r <= cal_ok ? `DSCM_APPLY_OK : `DSCM_APPLY_FAIL;
        end
    end

    // ==========================================
    // Current calendar, taken over only on a valid apply
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            CAL_TIME    <= `DSCM_TIME_RST;
            CAL_YEARWD  <= `DSCM_YEARWD_RST;
            CAL_DATE    <= `DSCM_DATE_RST;
            CAL_APPLIED <= 1'b0;
        end
        else
        begin
            CAL_APPLIED <= 1'b0;
            if (REG_WR && hit(REG_ADDR, `DSCM_ADR_APPLY)
                && REG_WDATA == `DSCM_APPLY_CMD && cal_ok)
            begin
                CAL_TIME    <= time_r;
                CAL_YEARWD  <= yearwd_r;
                CAL_DATE    <= date_r;
                CAL_APPLIED <= 1'b1;
            end
        end
    end

    // ==========================================
    // Broadcast inputs gated by their enables, extended commands out
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            DIGITAL_INPUT_FIVE  <= 1'b0;
            DIGITAL_INPUT_SIX   <= 1'b0;
            DIGITAL_INPUT_SEVEN <= 1'b0;
            EXT_INPUT_CMD       <= 3'h0;
        end
        else
        begin
            DIGITAL_INPUT_FIVE  <= BCAST_DIGITAL_INPUT_FIVE & cmdsel_r[`DSCM_CMDSEL_IN5];
            DIGITAL_INPUT_SIX   <= BCAST_DIGITAL_INPUT_SIX & cmdsel_r[`DSCM_CMDSEL_IN6];
            DIGITAL_INPUT_SEVEN <= BCAST_DIGITAL_INPUT_SEVEN & cmdsel_r[`DSCM_CMDSEL_IN7];
            EXT_INPUT_CMD       <= extin_r[2:0];
        end
    end

    // ==========================================
    // Read path, one cycle latency; unmapped reads give zero
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            REG_RDATA  <= 16'h0000;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                case (REG_ADDR)
                    `DSCM_ADR_CMDSEL: REG_RDATA <= cmdsel_r;
                    `DSCM_ADR_STATUS: REG_RDATA <= status_w;
                    `DSCM_ADR_FAULT1: REG_RDATA <= fault1_w;
                    `DSCM_ADR_EXTIN:  REG_RDATA <= extin_r;
                    `DSCM_ADR_TIME:   REG_RDATA <= time_r;
                    `DSCM_ADR_YEARWD: REG_RDATA <= yearwd_r;
                    `DSCM_ADR_DATE:   REG_RDATA <= date_r;
                    `DSCM_ADR_APPLY:  REG_RDATA <= apply_r;
                    default:          REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: dscm_map.vh
// What this block does
// - Bits D,E enable broadcast inputs six, seven
// - Register EXTENDED_INPUT_COMMANDS bits 0-2 are extended inputs
// - Time register holds HHMM, resets to 0000
// - Year 16-99 plus weekday code 01-06
// - Date register holds MMDD, resets to 101
// - Writing 1 to 3007 applies calendar
// - Apply status reads 0 ok, 8 fault
// - Monitor registers are read only
// - Status bits 0-4: run, reverse, ready, fault, error
// - Status bits 5-7 mirror relay and photo outputs
// - Status bit C flags safety input mismatch
// - Status bit D flags both safety inputs open
// - Status bits E,F show link reference, control
// - Fault word bits 0,1: overcurrent or earth leak, overvoltage
// - Bit C enables broadcast input five
// - Fault word at 0021, bit E link error
`ifndef DSCM_MAP_VH
`define DSCM_MAP_VH
// ==========================================
// Register addresses
`define DSCM_ADR_CMDSEL   16'h000F
`define DSCM_ADR_STATUS   16'h0020
`define DSCM_ADR_FAULT1   16'h0021
`define DSCM_ADR_EXTIN    16'h15C0
`define DSCM_ADR_TIME     16'h3004
`define DSCM_ADR_YEARWD   16'h3005
`define DSCM_ADR_DATE     16'h3006
`define DSCM_ADR_APPLY    16'h3007
// ==========================================
// Writable masks and field positions
`define DSCM_CMDSEL_MASK  16'h702E
`define DSCM_CMDSEL_IN5   12
`define DSCM_CMDSEL_IN6   13
`define DSCM_CMDSEL_IN7   14
`define DSCM_EXTIN_MASK   16'h0007
// ==========================================
// Reset values
`define DSCM_TIME_RST     16'h0000
`define DSCM_YEARWD_RST   16'h1001
`define DSCM_DATE_RST     16'h0065
`define DSCM_APPLY_RST    16'h0008
// ==========================================
// Apply command and responses
`define DSCM_APPLY_CMD    16'h0001
`define DSCM_APPLY_OK     16'h0000
`define DSCM_APPLY_FAIL   16'h0008
// ==========================================
// Calendar limits, decimal
`define DSCM_HOUR_MAX     7'd23
`define DSCM_MIN_MAX      7'd59
`define DSCM_YEAR_MIN     7'd16
`define DSCM_YEAR_MAX     7'd99
`define DSCM_WDAY_MIN     8'd1
`define DSCM_WDAY_MAX     8'd6
`define DSCM_MON_MAX      7'd12
`define DSCM_DAY_MAX      7'd31
`define DSCM_TIME_MAX     16'd2359
`define DSCM_DATE_MIN     16'd101
`define DSCM_DATE_MAX     16'd1231
`endif

// file: dscm_cal_check.v
`timescale 1ns/10ps
`default_nettype none
`include "dscm_map.vh"
module dscm_cal_check
(
    input  wire [15:0] time_val,
    input  wire [15:0] yearwd_val,
    input  wire [15:0] date_val,
    output wire        cal_ok
);
    // ==========================================
    // Range checks on decimal values
    wire [15:0] hh_q = time_val / 16'd100;
    wire [15:0] mm_q = time_val % 16'd100;
    wire [15:0] mo_q = date_val / 16'd100;
    wire [15:0] dd_q = date_val % 16'd100;
    // Quotients are small once the whole-value bounds hold, so the low bits suffice
    wire [6:0] hh = hh_q[6:0];
    wire [6:0] mm = mm_q[6:0];
    wire [6:0] mo = mo_q[6:0];
    wire [6:0] dd = dd_q[6:0];
    wire [6:0] yy = yearwd_val[14:8];
    wire [7:0] wd = yearwd_val[7:0];
    // Every field within its range
    assign cal_ok = (time_val <= `DSCM_TIME_MAX) && (hh <= `DSCM_HOUR_MAX)
                 && (mm <= `DSCM_MIN_MAX)
                 && (date_val >= `DSCM_DATE_MIN) && (date_val <= `DSCM_DATE_MAX)
                 && (mo >= 7'd1) && (mo <= `DSCM_MON_MAX)
                 && (dd >= 7'd1) && (dd <= `DSCM_DAY_MAX)
                 && (yearwd_val[15] == 1'b0)
                 && (yy >= `DSCM_YEAR_MIN) && (yy <= `DSCM_YEAR_MAX)
                 && (wd >= `DSCM_WDAY_MIN) && (wd <= `DSCM_WDAY_MAX);
endmodule
`default_nettype wire

// file: dscm_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks on the register bank
module dscm_regs_props
(
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_RVALID,
    input wire logic        SAFETY_INPUT_ONE,
    input wire logic        SAFETY_INPUT_TWO,
    input wire logic        BCAST_DIGITAL_INPUT_FIVE,
    input wire logic        DIGITAL_INPUT_FIVE,
    input wire logic [2:0]  EXT_INPUT_CMD,
    input wire logic [15:0] CAL_TIME,
    input wire logic        CAL_APPLIED
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Status read and apply command steps
    sequence rd_stat;
        REG_RD && REG_ADDR == 16'h0020;
    endsequence
    sequence apply_wr;
        REG_WR && REG_ADDR == 16'h3007 && REG_WDATA == 16'h0001;
    endsequence
    sequence rd_apply;
        REG_RD && REG_ADDR == 16'h3007;
    endsequence
    rvalid_after_rd_a: assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
    rvalid_idle_a: assert property (!REG_RD |=> !REG_RVALID) else $error("stray read answer");
    safety_mismatch_a: assert property (rd_stat |=> REG_RDATA[12] ==
        ($past(SAFETY_INPUT_ONE) ^ $past(SAFETY_INPUT_TWO))) else $error("bit C wrong");
    torque_removed_a: assert property (rd_stat |=> REG_RDATA[13] ==
        !($past(SAFETY_INPUT_ONE) | $past(SAFETY_INPUT_TWO))) else $error("bit D wrong");
    status_reserved_a: assert property (rd_stat |=> REG_RDATA[11:8] == 4'h0)
        else $error("reserved status bits set");
    input_five_gate_a: assert property (!BCAST_DIGITAL_INPUT_FIVE |=>
        !DIGITAL_INPUT_FIVE) else $error("input five passed");
    ext_cmd_load_a: assert property (REG_WR && REG_ADDR == 16'h15C0 |=> ##1
        EXT_INPUT_CMD == $past(REG_WDATA[2:0], 2)) else $error("ext command not loaded");
    apply_cause_a: assert property (CAL_APPLIED |-> $past(REG_WR) &&
        $past(REG_ADDR) == 16'h3007 && $past(REG_WDATA) == 16'h0001)
        else $error("apply without command");
    apply_status_a: assert property (apply_wr ##2 rd_apply |=>
        REG_RDATA == ($past(CAL_APPLIED, 2) ? 16'h0000 : 16'h0008))
        else $error("apply status wrong");
    cal_hold_a: assert property (!CAL_APPLIED |-> $stable(CAL_TIME))
        else $error("time moved without apply");
    unmapped_zero_a: assert property (REG_RD && REG_ADDR == 16'h0010 |=>
        REG_RDATA == 16'h0000) else $error("unmapped read not zero");
endmodule
bind dscm_regs dscm_regs_props chk_u
(
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .SAFETY_INPUT_ONE(SAFETY_INPUT_ONE), .SAFETY_INPUT_TWO(SAFETY_INPUT_TWO),
    .BCAST_DIGITAL_INPUT_FIVE(BCAST_DIGITAL_INPUT_FIVE),
    .DIGITAL_INPUT_FIVE(DIGITAL_INPUT_FIVE), .EXT_INPUT_CMD(EXT_INPUT_CMD),
    .CAL_TIME(CAL_TIME), .CAL_APPLIED(CAL_APPLIED)
);
`default_nettype wire

// file: dscm_master.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Parallel bus master: one word per request, released lines inverted
module dscm_master
(
    input  wire logic        clk,
    output var  logic [15:0] addr,
    output var  logic [15:0] wdata,
    output var  logic        wr,
    output var  logic        rd,
    input  wire logic [15:0] rdata
);
    initial
        {addr, wdata, wr, rd} = 34'h0;
    // Write strobe spans one rising edge
    task wr16(input logic [15:0] a, input logic [15:0] d);
    begin
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        {addr, wdata, wr} = {~a, ~d, 1'b0};
    end
    endtask
    // Read answer is settled at the next falling edge
    task rd16(input logic [15:0] a, output logic [15:0] d);
    begin
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        d = rdata;
        {addr, rd} = {~a, 1'b0};
    end
    endtask
endmodule
`default_nettype wire

// file: dscm_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dscm_regs_tb;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [18:0] st = 19'h0;
    logic [15:0] addr, wdata, rdata, q, r, t, y, dt, ct, cy, cd;
    logic [15:0] xt = 16'h0000;
    logic [15:0] xy = 16'h1001;
    logic [15:0] xd = 16'h0065;
    logic        wr, rd, rvalid, applied, d5, d6, d7;
    logic [2:0]  ext;
    logic [15:0] ra [7] = '{16'h000F, 16'h15C0, 16'h3004, 16'h3005, 16'h3006, 16'h3007, 16'h0010};
    logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0, 16'h1001, 16'h0065, 16'h0008, 16'h0};
    integer      seed = 46300;
    integer      n_mismatch = 0;
    integer      n_compared = 0;
    integer      cyc = 0;
    integer      i;
    // ==========================================
    // Design and master
    dscm_master mst_u (.clk(clk_sys), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    dscm_regs dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .RUNNING(st[0]),
        .REVERSE(st[1]), .READY(st[2]), .FAULT(st[3]), .PARAMETER_SETTING_ERROR(st[4]),
        .RELAY_OUTPUT(st[5]), .PHOTO_OUTPUT_ONE(st[6]), .PHOTO_OUTPUT_TWO(st[7]),
        .SAFETY_INPUT_ONE(st[8]), .SAFETY_INPUT_TWO(st[9]), .LINK_SPEED_REFERENCE_ACTIVE(st[10]),
        .LINK_RUN_CONTROL_ACTIVE(st[11]), .OVERCURRENT_FAULT(st[12]), .EARTH_LEAK_FAULT(st[13]),
        .OVERVOLTAGE_FAULT(st[14]), .LINK_COMM_ERROR(st[15]), .BCAST_DIGITAL_INPUT_FIVE(st[16]),
        .BCAST_DIGITAL_INPUT_SIX(st[17]), .BCAST_DIGITAL_INPUT_SEVEN(st[18]),
        .DIGITAL_INPUT_FIVE(d5), .DIGITAL_INPUT_SIX(d6), .DIGITAL_INPUT_SEVEN(d7),
        .EXT_INPUT_CMD(ext), .CAL_TIME(ct), .CAL_YEARWD(cy), .CAL_DATE(cd), .CAL_APPLIED(applied));
    always #2 clk_sys = ~clk_sys;
    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            conclude;
        end
    end
    // ==========================================
    // Expected words and checking
    function logic [15:0] f_stat(input logic [18:0] s);
        f_stat = {s[11], s[10], ~(s[8] | s[9]), s[8] ^ s[9], 4'h0, s[7:0]};
    endfunction
    function logic [15:0] f_flt(input logic [18:0] s);
        f_flt = {1'b0, s[15], 12'h000, s[14], s[12] | s[13]};
    endfunction
    task chk(input logic [15:0] g, input logic [15:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task conclude;
    begin
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        for (i = 0; i < 7; i++)
        begin
            mst_u.rd16(ra[i], r);
            chk(r, rv[i]);
            chk({15'h0, rvalid}, 16'h0001);
        end
        chk(ct, xt);
        chk(cy, xy);
        chk(cd, xd);
        for (i = 0; i < 24; i++)
        begin
            st = 19'($random(seed));
            r = (i == 0) ? 16'hFFFF : 16'($random(seed));
            mst_u.wr16(16'h000F, r);
            mst_u.wr16(16'h0020, r);
            mst_u.wr16(16'h0021, r);
            mst_u.wr16(16'h0010, r);
            mst_u.rd16(16'h0020, q);
            chk(q, f_stat(st));
            mst_u.rd16(16'h0021, q);
            chk(q, f_flt(st));
            chk({13'h0, d7, d6, d5}, {13'h0, st[18:16] & r[14:12]});
            mst_u.rd16(16'h000F, q);
            chk(q, r & 16'h702E);
            mst_u.rd16(16'h0010, q);
            chk(q, 16'h0000);
            mst_u.wr16(16'h15C0, r);
            mst_u.rd16(16'h15C0, q);
            chk(q, r & 16'h0007);
            chk({13'h0, ext}, {13'h0, r[2:0]});
            t = 16'(100 * ({$random(seed)} % 24) + {$random(seed)} % 60);
            y = 16'(256 * (16 + {$random(seed)} % 84) + 1 + {$random(seed)} % 6);
            dt = 16'(100 * (1 + {$random(seed)} % 12) + 1 + {$random(seed)} % 31);
            if (i == 0)
                {t, y, dt} = {16'd2359, 16'h6306, 16'd1231};
            if (i == 23)
                t = 16'd2360;
            mst_u.wr16(16'h3004, t);
            mst_u.wr16(16'h3005, y);
            mst_u.wr16(16'h3006, dt);
            mst_u.wr16(16'h3007, (i == 22) ? 16'h0002 : 16'h0001);
            if (i < 22)
                {xt, xy, xd} = {t, y, dt};
            chk({15'h0, applied}, (i < 22) ? 16'h0001 : 16'h0000);
            chk(ct, xt);
            chk(cy, xy);
            chk(cd, xd);
            mst_u.rd16(16'h3007, q);
            chk(q, (i == 23) ? 16'h0008 : 16'h0000);
            mst_u.rd16(16'h3004, q);
            chk(q, t);
        end
        conclude;
    end
endmodule
`default_nettype wire
